/* rtl/stcmd_pkg.sv */
// Function
// - control 0010 disables step delay timer
// - control 0110 enables step delay timer
// - control 1000/1001 start timer, wait limit
// - control 1011 waits software trigger rising edge
// - control 1100/1101 load counter into channel-select
// - control 1110 loads literal0 into channel-select
// - control 1111 emits enabled broadcast triggers
// - reserved options execute as no-operation
// - add 0000/0001 adds adjust into counter limits
// - add 0010/0011 adds adjust into timer limits
// - add 0100/0101 adds adjust into delay, literal0
// - copy 1000/1001 hold into counter limits
// - copy 1010/1011 hold into timer limits
// - copy 1100/1101 hold into delay, literal0
package stcmd_pkg;
    // command codes in the high nibble of the step byte
    localparam logic [3:0] CMD_CTRL = 4'h1;
    localparam logic [3:0] CMD_ADDCOPY = 4'h2;
    // control options
    localparam logic [3:0] OPT_SD_OFF = 4'h2;
    localparam logic [3:0] OPT_SD_ON = 4'h6;
    localparam logic [3:0] OPT_T0_WAIT = 4'h8;
    localparam logic [3:0] OPT_T1_WAIT = 4'h9;
    localparam logic [3:0] OPT_SWT_WAIT = 4'hb;
    localparam logic [3:0] OPT_CHS_C0 = 4'hc;
    localparam logic [3:0] OPT_CHS_C1 = 4'hd;
    localparam logic [3:0] OPT_CHS_L0 = 4'he;
    localparam logic [3:0] OPT_BCAST = 4'hf;
    // add/copy targets (low three option bits)
    localparam logic [2:0] TGT_C0LIM = 3'h0;
    localparam logic [2:0] TGT_C1LIM = 3'h1;
    localparam logic [2:0] TGT_T0LIM = 3'h2;
    localparam logic [2:0] TGT_T1LIM = 3'h3;
    localparam logic [2:0] TGT_SDLIM = 3'h4;
    localparam logic [2:0] TGT_LIT0 = 3'h5;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    localparam logic SD_EN_RST = 1'b0;

    typedef struct packed {
        logic [15:0] counter0_limit;
        logic [15:0] counter1_limit;
        logic [15:0] timer0_limit;
        logic [15:0] timer1_limit;
        logic [15:0] step_delay_limit;
        logic [15:0] literal0_value;
    } stcmd_limits_t;

    typedef enum logic [1:0] {ST_IDLE, ST_WAIT_T0, ST_WAIT_T1, ST_WAIT_SWT} stcmd_state_t;
endpackage : stcmd_pkg

/* rtl/stcmd_exec.sv */
`timescale 1ns/1ps
`default_nettype none
module stcmd_exec #(
    parameter int TRIG_W = 16
) (
    input  wire logic                   i_clk,
    input  wire logic                   i_rstn,
    input  wire logic                   i_step_valid,
    input  wire logic [7:0]             i_step_byte,
    input  wire logic [15:0]            i_adjust_value,
    input  wire logic [15:0]            i_hold_value,
    input  wire logic [15:0]            i_counter0,
    input  wire logic [15:0]            i_counter1,
    input  wire logic [15:0]            i_timer0,
    input  wire logic [15:0]            i_timer1,
    input  wire logic                   i_software_trigger_bit,
    input  wire logic [TRIG_W-1:0]      i_broadcast_trigger_enable,
    output logic                        o_step_done,
    output logic                        o_busy,
    output logic                        o_timer0_run,
    output logic                        o_timer1_run,
    output logic                        o_step_delay_en,
    output logic [15:0]                 o_converter_channel_select,
    output logic                        o_chs_load,
    output logic [TRIG_W-1:0]           o_trigger,
    output stcmd_pkg::stcmd_limits_t    o_limits
);
    // elaboration check on the trigger width
    if (TRIG_W < 1 || TRIG_W > 32) begin : g_bad_trig_w
        $error("TRIG_W out of range");
    end

    ////////////////////////////////////////////////////////////////////////
    stcmd_pkg::stcmd_state_t state, next_state;
    stcmd_pkg::stcmd_limits_t lim, next_lim;
    logic              sd_en, next_sd_en;
    logic              t0_run, next_t0_run, t1_run, next_t1_run;
    logic [15:0]       chs, next_chs;
    logic              chs_ld, next_chs_ld;
    logic [TRIG_W-1:0] trig, next_trig;
    logic              done, next_done;
    logic              busy, next_busy;
    logic              swt_prev;
    logic [3:0]        cmd, opt;
    logic [15:0]       src;

    // wrapping add or plain copy into a target word
    function automatic logic [15:0] upd(input logic [15:0] old, input logic [15:0] s,
                                        input logic is_copy);
        upd = is_copy ? s : 16'(old + s);
    endfunction : upd

    assign cmd = i_step_byte[7:4];
    assign opt = i_step_byte[3:0];
    assign src = opt[3] ? i_hold_value : i_adjust_value;

    // next-state decode and execution
    always_comb begin
        next_state  = state;
        next_lim    = lim;
        next_sd_en  = sd_en;
        next_t0_run = t0_run;
        next_t1_run = t1_run;
        next_chs    = chs;
        next_chs_ld = 1'b0;
        next_trig   = '0;
        next_done   = 1'b0;
        unique case (state)
            stcmd_pkg::ST_IDLE: begin
                if (i_step_valid && cmd == stcmd_pkg::CMD_CTRL) begin
                    next_done = 1'b1;
                    case (opt)
                        stcmd_pkg::OPT_SD_OFF: next_sd_en = 1'b0;
                        stcmd_pkg::OPT_SD_ON:  next_sd_en = 1'b1;
                        stcmd_pkg::OPT_T0_WAIT: begin
                            next_t0_run = 1'b1;
                            next_done   = 1'b0;
                            next_state  = stcmd_pkg::ST_WAIT_T0;
                        end
                        stcmd_pkg::OPT_T1_WAIT: begin
                            next_t1_run = 1'b1;
                            next_done   = 1'b0;
                            next_state  = stcmd_pkg::ST_WAIT_T1;
                        end
                        stcmd_pkg::OPT_SWT_WAIT: begin
                            next_done  = 1'b0;
                            next_state = stcmd_pkg::ST_WAIT_SWT;
                        end
                        stcmd_pkg::OPT_CHS_C0: begin
                            next_chs    = i_counter0;
                            next_chs_ld = 1'b1;
                        end
                        stcmd_pkg::OPT_CHS_C1: begin
                            next_chs    = i_counter1;
                            next_chs_ld = 1'b1;
                        end
                        stcmd_pkg::OPT_CHS_L0: begin
                            next_chs    = lim.literal0_value;
                            next_chs_ld = 1'b1;
                        end
                        stcmd_pkg::OPT_BCAST: next_trig = i_broadcast_trigger_enable;
                        default: ;
                    endcase
                end else if (i_step_valid && cmd == stcmd_pkg::CMD_ADDCOPY) begin
                    next_done = 1'b1;
                    case (opt[2:0])
                        stcmd_pkg::TGT_C0LIM: next_lim.counter0_limit =
                            upd(lim.counter0_limit, src, opt[3]);
                        stcmd_pkg::TGT_C1LIM: next_lim.counter1_limit =
                            upd(lim.counter1_limit, src, opt[3]);
                        stcmd_pkg::TGT_T0LIM: next_lim.timer0_limit =
                            upd(lim.timer0_limit, src, opt[3]);
                        stcmd_pkg::TGT_T1LIM: next_lim.timer1_limit =
                            upd(lim.timer1_limit, src, opt[3]);
                        stcmd_pkg::TGT_SDLIM: next_lim.step_delay_limit =
                            upd(lim.step_delay_limit, src, opt[3]);
                        stcmd_pkg::TGT_LIT0: next_lim.literal0_value =
                            upd(lim.literal0_value, src, opt[3]);
                        default: ;
                    endcase
                end else if (i_step_valid) begin
                    next_done = 1'b1; // other codes pass as no-operation
                end
            end
            stcmd_pkg::ST_WAIT_T0: begin
                if (i_timer0 == lim.timer0_limit) begin
                    next_t0_run = 1'b0;
                    next_done   = 1'b1;
                    next_state  = stcmd_pkg::ST_IDLE;
                end
            end
            stcmd_pkg::ST_WAIT_T1: begin
                if (i_timer1 == lim.timer1_limit) begin
                    next_t1_run = 1'b0;
                    next_done   = 1'b1;
                    next_state  = stcmd_pkg::ST_IDLE;
                end
            end
            stcmd_pkg::ST_WAIT_SWT: begin
                if (i_software_trigger_bit && !swt_prev) begin
                    next_done  = 1'b1;
                    next_state = stcmd_pkg::ST_IDLE;
                end
            end
        endcase
        next_busy = (next_state != stcmd_pkg::ST_IDLE); // busy is registered, not decoded
    end

    // state registers
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            state    <= stcmd_pkg::ST_IDLE;
            lim      <= {6{stcmd_pkg::RST_WORD}};
            sd_en    <= stcmd_pkg::SD_EN_RST;
            t0_run   <= 1'b0;
            t1_run   <= 1'b0;
            chs      <= stcmd_pkg::RST_WORD;
            chs_ld   <= 1'b0;
            trig     <= '0;
            done     <= 1'b0;
            swt_prev <= 1'b1;
            busy     <= 1'b0;
        end else begin
            state    <= next_state;
            lim      <= next_lim;
            sd_en    <= next_sd_en;
            t0_run   <= next_t0_run;
            t1_run   <= next_t1_run;
            chs      <= next_chs;
            chs_ld   <= next_chs_ld;
            trig     <= next_trig;
            done     <= next_done;
            swt_prev <= i_software_trigger_bit;
            busy     <= next_busy;
        end
    end

    // outputs straight from flops
    assign o_step_done                = done;
    assign o_busy                     = busy;
    assign o_timer0_run               = t0_run;
    assign o_timer1_run               = t1_run;
    assign o_step_delay_en            = sd_en;
    assign o_converter_channel_select = chs;
    assign o_chs_load                 = chs_ld;
    assign o_trigger                  = trig;
    assign o_limits                   = lim;

    ////////////////////////////////////////////////////////////////////////
    // checks
    logic idle_step;
    assign idle_step = i_step_valid && state == stcmd_pkg::ST_IDLE;

    chk_sd_off: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_CTRL, stcmd_pkg::OPT_SD_OFF}
        |=> !o_step_delay_en && o_step_done) else $error("delay timer not disabled");
    chk_sd_on: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_CTRL, stcmd_pkg::OPT_SD_ON}
        |=> o_step_delay_en) else $error("delay timer not enabled");
    chk_timer0_wait: assert property (@(posedge i_clk) disable iff (!i_rstn)
        state == stcmd_pkg::ST_WAIT_T0 && i_timer0 != lim.timer0_limit
        |=> !o_step_done && o_timer0_run) else $error("timer0 wait ended early");
    chk_swt_edge: assert property (@(posedge i_clk) disable iff (!i_rstn)
        state == stcmd_pkg::ST_WAIT_SWT && $rose(i_software_trigger_bit)
        |=> o_step_done && !o_busy) else $error("software edge missed");
    chk_swt_level: assert property (@(posedge i_clk) disable iff (!i_rstn)
        state == stcmd_pkg::ST_WAIT_SWT && !$rose(i_software_trigger_bit)
        |=> o_busy) else $error("wait left without edge");
    chk_chs_counter: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_CTRL, stcmd_pkg::OPT_CHS_C0}
        |=> o_converter_channel_select == $past(i_counter0) && o_chs_load)
        else $error("counter0 not loaded");
    chk_bcast: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_CTRL, stcmd_pkg::OPT_BCAST}
        |=> o_trigger == $past(i_broadcast_trigger_enable)) else $error("broadcast wrong");
    chk_add_wrap: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_ADDCOPY, 4'h0}
        |=> o_limits.counter0_limit == 16'($past(lim.counter0_limit) + $past(i_adjust_value)))
        else $error("add result wrong");
    chk_copy_lit: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_ADDCOPY, 4'hd}
        |=> o_limits.literal0_value == $past(i_hold_value)) else $error("copy result wrong");
    chk_reserved: assert property (@(posedge i_clk) disable iff (!i_rstn)
        idle_step && i_step_byte == {stcmd_pkg::CMD_ADDCOPY, 4'he}
        |=> $stable(o_limits)) else $error("reserved option had effect");

    cov_timer1: cover property (@(posedge i_clk) state == stcmd_pkg::ST_WAIT_T1 ##1 o_step_done);
    cov_swt: cover property (@(posedge i_clk) state == stcmd_pkg::ST_WAIT_SWT ##1 o_step_done);
    cov_bcast: cover property (@(posedge i_clk) o_trigger != '0);
endmodule : stcmd_exec
`default_nettype wire

/* tb/stcmd_timer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module stcmd_timer_model (
    input  wire logic        i_clk,
    input  wire logic        i_rstn,
    input  wire logic        i_run0,
    input  wire logic        i_run1,
    output logic [15:0]      o_timer0,
    output logic [15:0]      o_timer1
);
    // general timers count while started and clear while stopped, so each wait starts at zero
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_timer0 <= 16'h0000;
            o_timer1 <= 16'h0000;
        end else begin
            o_timer0 <= i_run0 ? o_timer0 + 16'h0001 : 16'h0000;
            o_timer1 <= i_run1 ? o_timer1 + 16'h0001 : 16'h0000;
        end
    end
endmodule : stcmd_timer_model
`default_nettype wire

/* tb/trigger_step_cmd_options_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module trigger_step_cmd_options_bench;
    logic                       clk = 1'b0, rstn = 1'b0, valid = 1'b0, swt = 1'b1;
    logic [7:0]                 byte_in = 8'h00;
    logic [15:0]                adj = 16'h0000, hold = 16'h0000, cnt0 = 16'h0000;
    logic [15:0]                cnt1 = 16'h0000, mask = 16'h0000, tmr0, tmr1, chs, trig, tg;
    logic                       done, busy, run0, run1, sd_en, chs_load, ld;
    stcmd_pkg::stcmd_limits_t   lim;
    logic [95:0]                exp;
    logic [7:0]                 rsv [13] = '{8'h10, 8'h11, 8'h13, 8'h14, 8'h15, 8'h17, 8'h1a,
                                             8'h26, 8'h27, 8'h2e, 8'h2f, 8'h00, 8'h3f};
    int                         miscompares = 0, checks = 0, n;

    stcmd_exec #(.TRIG_W(16)) stcmd_exec_inst (
        .i_clk(clk), .i_rstn(rstn), .i_step_valid(valid), .i_step_byte(byte_in),
        .i_adjust_value(adj), .i_hold_value(hold), .i_counter0(cnt0), .i_counter1(cnt1),
        .i_timer0(tmr0), .i_timer1(tmr1), .i_software_trigger_bit(swt),
        .i_broadcast_trigger_enable(mask), .o_step_done(done), .o_busy(busy),
        .o_timer0_run(run0), .o_timer1_run(run1), .o_step_delay_en(sd_en),
        .o_converter_channel_select(chs), .o_chs_load(chs_load), .o_trigger(trig),
        .o_limits(lim));
    stcmd_timer_model stcmd_timer_model_inst (
        .i_clk(clk), .i_rstn(rstn), .i_run0(run0), .i_run1(run1),
        .o_timer0(tmr0), .o_timer1(tmr1));

    // 100 ns clock
    always #50 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////////
    // compare, step presentation and verdict
    task chk(input string what, input logic [95:0] seen, input logic [95:0] want);
        checks++;
        if (seen !== want) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, want, seen);
        end
    endtask : chk

    task go(input logic [7:0] b);
        @(posedge clk);
        valid   <= 1'b1;
        byte_in <= b;
        @(posedge clk);
        valid   <= 1'b0;
        #1;
    endtask : go

    // waits for the done pulse and keeps what stood beside it
    task wait_done(output int c);
        c = 0;
        while (done !== 1'b1 && c < 300) begin
            @(posedge clk);
            #1;
            c++;
        end
        chk("done", {95'h0, done}, 96'h1);
        ld = chs_load;
        tg = trig;
    endtask : wait_done

    task step(input logic [7:0] b);
        go(b);
        wait_done(n);
    endtask : step

    task results;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : results

    ////////////////////////////////////////////////////////////////////////////////
    // tests
    initial begin
        repeat (12) @(posedge clk);
        rstn <= 1'b1;
        exp = '0;
        #1;
        chk("limits", lim, exp);
        chk("sd_chs", 96'({sd_en, chs}), 96'h0);
        step(8'h16);
        chk("sd_en", {95'h0, sd_en}, 96'h1);
        step(8'h12);
        chk("sd_en", {95'h0, sd_en}, 96'h0);
        $display("test step delay over");
        for (int t = 0; t < 6; t++) begin
            @(posedge clk) hold <= 16'hff00 + 16'(t);
            step(8'h28 + 8'(t));
            exp[95-16*t -: 16] = 16'hff00 + 16'(t);
            chk("copy", lim, exp);
        end
        @(posedge clk) adj <= 16'h0200;
        for (int t = 0; t < 6; t++) begin
            step(8'h20 + 8'(t));
            exp[95-16*t -: 16] = exp[95-16*t -: 16] + 16'h0200;
            chk("add", lim, exp);
        end
        $display("test add copy over");
        foreach (rsv[i]) begin
            step(rsv[i]);
            chk("reserved", lim, exp);
            chk("reserved_sd", 96'(sd_en), 96'h0);
            chk("reserved_pulse", 96'({ld, tg}), 96'h0);
        end
        $display("test reserved over");
        @(posedge clk);
        cnt0 <= 16'h1234;
        cnt1 <= 16'habcd;
        step(8'h1c);
        chk("chs_c0", 96'({ld, chs}), {79'h0, 1'b1, 16'h1234});
        step(8'h1d);
        chk("chs_c1", 96'({ld, chs}), {79'h0, 1'b1, 16'habcd});
        step(8'h1e);
        chk("chs_l0", 96'({ld, chs}), {79'h0, 1'b1, exp[15:0]});
        @(posedge clk) mask <= 16'ha5c3;
        step(8'h1f);
        chk("trigger", 96'(tg), 96'ha5c3);
        @(posedge clk);
        #1;
        chk("trigger_end", 96'(trig), 96'h0);
        $display("test channel trigger over");
        @(posedge clk) hold <= 16'h0005;
        step(8'h2a);
        go(8'h18);
        chk("run0", 96'({busy, run0, run1}), 96'h6);
        wait_done(n);
        // timer starts from zero one edge after the take, so limit plus one edges
        chk("wait0", 96'({busy, run0, n == 6}), 96'h1);
        @(posedge clk) hold <= 16'h0003;
        step(8'h2b);
        go(8'h19);
        chk("run1", 96'({busy, run0, run1}), 96'h5);
        wait_done(n);
        chk("wait1", 96'({busy, run1, n == 4}), 96'h1);
        $display("test timer wait over");
        go(8'h1b);
        repeat (4) @(posedge clk);
        #1;
        chk("swt_high", {95'h0, busy}, 96'h1);
        // a step offered while waiting is ignored
        go(8'h16);
        chk("busy_ignored", 96'({busy, sd_en}), 96'h2);
        @(posedge clk) swt <= 1'b0;
        @(posedge clk) swt <= 1'b1;
        #1;
        chk("swt_low", {95'h0, busy}, 96'h1);
        wait_done(n);
        chk("swt_rise", 96'({busy, n == 1}), 96'h1);
        $display("test software wait over");
        results();
    end

    // watchdog well beyond the expected run
    initial begin
        repeat (5000) @(posedge clk);
        miscompares++;
        results();
    end
endmodule : trigger_step_cmd_options_bench
`default_nettype wire
